// file: inc/swg_pkg.sv
package swg_pkg;
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_PROTECT = 8'h36;
	localparam logic [7:0] OP_UNPROTECT = 8'h39;
	localparam int SECTOR_COUNT = 32;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_MSB = 20;
	localparam int ADDR_BYTES = 3;
	localparam logic [SECTOR_COUNT-1:0] GUARD_RESET = 32'hFFFFFFFF;
	localparam logic WRITE_PERMIT_RESET = 1'b0;
	localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// file: inc/swg_link_if.sv
`timescale 1ns/100ps
interface swg_link_if;
	logic sck_rise;
	logic frame_start;
	logic frame_end;
	logic sdi;
	modport front (output sck_rise, output frame_start, output frame_end, output sdi);
	modport core (input sck_rise, input frame_start, input frame_end, input sdi);
endinterface

// file: hw/swg_pin_front.sv
`timescale 1ns/100ps
// synchronises the serial pins and flags clock rises and frame edges
module swg_pin_front (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	swg_link_if.front link
);
	logic [1:0] sck_s_r, sck_s_nxt;
	logic [1:0] cs_s_r, cs_s_nxt;
	logic [1:0] sdi_s_r, sdi_s_nxt;
	logic sck_d_r, sck_d_nxt;
	logic cs_d_r, cs_d_nxt;

	always_comb begin
		sck_s_nxt = {sck_s_r[0], sck_i};
		cs_s_nxt = {cs_s_r[0], cs_n_i};
		sdi_s_nxt = {sdi_s_r[0], sdi_i};
		sck_d_nxt = sck_s_r[1];
		cs_d_nxt = cs_s_r[1];
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sck_s_r <= swg_pkg::SYNC_RESET;
			cs_s_r <= 2'h3;
			sdi_s_r <= swg_pkg::SYNC_RESET;
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			sck_s_r <= sck_s_nxt;
			cs_s_r <= cs_s_nxt;
			sdi_s_r <= sdi_s_nxt;
			sck_d_r <= sck_d_nxt;
			cs_d_r <= cs_d_nxt;
		end
	end

	// rises counted only inside a frame
	assign link.sck_rise = sck_s_r[1] & ~sck_d_r & ~cs_s_r[1];
	assign link.frame_start = cs_d_r & ~cs_s_r[1];
	assign link.frame_end = ~cs_d_r & cs_s_r[1];
	assign link.sdi = sdi_s_r[1];
endmodule

// file: hw/swg_guard.sv
`timescale 1ns/100ps
// Behaviour
// - a complete set-latch opcode closed by chip-select release sets the write permit latch.
// - protect and unprotect run only when the write permit latch was already set, else they are discarded.
// - bytes after a set-latch or clear-latch opcode are ignored.
// - a frame ending before the opcode is whole, or a set-latch or clear-latch frame off a byte boundary, leaves the latch unchanged.
// - a complete clear-latch opcode closed by chip-select release clears the latch.
// - one guard bit per 64KB sector, all set at power-up.
// - program and erase of a sector are allowed only while its guard bit is zero.
// - protect with three address bytes sets the addressed guard bit at release, extra bytes ignored.
// - a finished protect or unprotect clears the latch.
// - a short or misaligned protect frame leaves the guard bit and clears the latch.
// - unprotect with three address bytes clears the addressed guard bit at release, extra bytes ignored.
// - a short or misaligned unprotect frame leaves the guard bit and clears the latch.
// - with the lock set a protect is ignored, the latch cleared and the block goes idle.
// - with the lock set an unprotect is ignored, the latch cleared and the block goes idle.
// - while a program or erase is suspended protect and unprotect opcodes change nothing.
module swg_guard (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic guard_regs_lock_i,
	input wire logic suspended_i,
	input wire logic [4:0] query_sector_i,
	output logic write_permit_latch_o,
	output logic [swg_pkg::SECTOR_COUNT-1:0] sector_guard_bits_o,
	output logic query_allowed_o
);
	typedef enum logic [1:0] {
		SWG_IDLE = 2'b00,
		SWG_OPCODE = 2'b01,
		SWG_ADDR = 2'b10,
		SWG_DRAIN = 2'b11
	} swg_state_t;

	swg_link_if link ();

	swg_pin_front u_front (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.sck_i(sck_i),
		.cs_n_i(cs_n_i),
		.sdi_i(sdi_i),
		.link(link)
	);

	swg_state_t state_r, state_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [1:0] byte_cnt_r, byte_cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] opcode_r, opcode_nxt;
	logic [4:0] sector_r, sector_nxt;
	logic addr_done_r, addr_done_nxt;
	logic latch_r, latch_nxt;
	logic [swg_pkg::SECTOR_COUNT-1:0] guard_r, guard_nxt;
	logic allowed_r, allowed_nxt;
	logic [7:0] byte_in;
	logic is_guard_op;
	logic bit_taken;
	logic byte_done;
	logic opcode_whole;
	logic on_boundary;
	logic frame_done;
	logic latch_set_go;
	logic latch_clr_go;
	logic guard_taken;
	logic guard_write_go;
	logic guard_value;

	assign byte_in = {shift_r[6:0], link.sdi};
	assign is_guard_op = (opcode_r == swg_pkg::OP_PROTECT) || (opcode_r == swg_pkg::OP_UNPROTECT);
	assign bit_taken = link.sck_rise && (state_r != SWG_IDLE);
	assign byte_done = bit_taken && (bit_cnt_r == 3'h7);
	// a frame only counts once its opcode byte is whole
	assign opcode_whole = (state_r == SWG_ADDR) || (state_r == SWG_DRAIN);
	assign on_boundary = (bit_cnt_r == 3'h0);
	assign frame_done = link.frame_end && opcode_whole;
	assign latch_set_go = frame_done && on_boundary && (opcode_r == swg_pkg::OP_SET_LATCH);
	assign latch_clr_go = frame_done && on_boundary && (opcode_r == swg_pkg::OP_CLR_LATCH);
	// a guard opcode without the latch, or while suspended, leaves everything as it was
	assign guard_taken = frame_done && is_guard_op && !suspended_i && latch_r;
	// lock, a short address or a cut byte abort the update but the latch is still cleared
	assign guard_write_go = guard_taken && !guard_regs_lock_i && addr_done_r && on_boundary;
	assign guard_value = (opcode_r == swg_pkg::OP_PROTECT);

	// frame tracking: state, bit and byte counts
	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		byte_cnt_nxt = byte_cnt_r;
		addr_done_nxt = addr_done_r;
		if (link.frame_start) begin
			state_nxt = SWG_OPCODE;
			bit_cnt_nxt = 3'h0;
			byte_cnt_nxt = 2'h0;
			addr_done_nxt = 1'b0;
		end else if (link.frame_end) begin
			state_nxt = SWG_IDLE;
		end else if (bit_taken) begin
			bit_cnt_nxt = bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				unique case (state_r)
					SWG_OPCODE: begin
						if (byte_in == swg_pkg::OP_PROTECT || byte_in == swg_pkg::OP_UNPROTECT) begin
							state_nxt = SWG_ADDR;
						end else begin
							state_nxt = SWG_DRAIN;
						end
					end
					SWG_ADDR: begin
						byte_cnt_nxt = byte_cnt_r + 2'h1;
						if (byte_cnt_r == 2'(swg_pkg::ADDR_BYTES - 1)) begin
							addr_done_nxt = 1'b1;
							state_nxt = SWG_DRAIN;
						end
					end
					SWG_IDLE, SWG_DRAIN: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= SWG_IDLE;
			bit_cnt_r <= 3'h0;
			byte_cnt_r <= 2'h0;
			addr_done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			byte_cnt_r <= byte_cnt_nxt;
			addr_done_r <= addr_done_nxt;
		end
	end

	// byte capture: shifts bits in, keeps the opcode and the sector of the first address byte
	always_comb begin
		shift_nxt = shift_r;
		opcode_nxt = opcode_r;
		sector_nxt = sector_r;
		if (link.frame_start) begin
			opcode_nxt = 8'h00;
		end else if (bit_taken) begin
			shift_nxt = byte_in;
			if (byte_done && state_r == SWG_OPCODE) begin
				opcode_nxt = byte_in;
			end
			if (byte_done && state_r == SWG_ADDR && byte_cnt_r == 2'h0) begin
				sector_nxt = byte_in[swg_pkg::SECTOR_MSB-16:swg_pkg::SECTOR_LSB-16];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shift_r <= 8'h00;
			opcode_r <= 8'h00;
			sector_r <= 5'h00;
		end else begin
			shift_r <= shift_nxt;
			opcode_r <= opcode_nxt;
			sector_r <= sector_nxt;
		end
	end

	// write permit latch
	always_comb begin
		latch_nxt = latch_r;
		if (latch_set_go) begin
			latch_nxt = 1'b1;
		end else if (latch_clr_go || guard_taken) begin
			latch_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			latch_r <= swg_pkg::WRITE_PERMIT_RESET;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	// one guard bit per sector, written only by a complete unlocked guard frame
	generate
		for (genvar g = 0; g < swg_pkg::SECTOR_COUNT; g++) begin : g_guard
			always_comb begin
				guard_nxt[g] = guard_r[g];
				if (guard_write_go && (sector_r == 5'(g))) begin
					guard_nxt[g] = guard_value;
				end
			end

			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					guard_r[g] <= swg_pkg::GUARD_RESET[g];
				end else begin
					guard_r[g] <= guard_nxt[g];
				end
			end
		end
	endgenerate

	// permission follows the guard bit that the queried sector is about to hold
	always_comb begin
		allowed_nxt = ~guard_nxt[query_sector_i];
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			allowed_r <= 1'b0;
		end else begin
			allowed_r <= allowed_nxt;
		end
	end

	// outputs come straight from their registers
	assign write_permit_latch_o = latch_r;
	assign sector_guard_bits_o = guard_r;
	assign query_allowed_o = allowed_r;
endmodule

// file: verification/swg_guard_monitor.sv
`timescale 1ns/100ps
module swg_guard_monitor (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic guard_regs_lock_i,
	input wire logic suspended_i,
	input wire logic [4:0] query_sector_i,
	input wire logic write_permit_latch_o,
	input wire logic [swg_pkg::SECTOR_COUNT-1:0] sector_guard_bits_o,
	input wire logic query_allowed_o
);
	logic [4:0] qs_d_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_closed; $past(cs_n_i, 3); endsequence
	always_ff @(posedge clk_i) qs_d_r <= query_sector_i;
	a_guard_reset: assert property (disable iff (1'h0) sys_rst_i |=> &sector_guard_bits_o)
		else $error("guard reset");
	a_latch_quiet: assert property (!$stable(write_permit_latch_o) |-> s_closed)
		else $error("latch moved in frame");
	a_guard_quiet: assert property (!$stable(sector_guard_bits_o) |-> s_closed)
		else $error("guard moved in frame");
	a_guard_clears: assert property (!$stable(sector_guard_bits_o) |-> ##[0:1] !write_permit_latch_o)
		else $error("latch kept");
	a_guard_needs: assert property (!$stable(sector_guard_bits_o) |-> $past(write_permit_latch_o, 6))
		else $error("guard without latch");
	a_lock_holds: assert property (guard_regs_lock_i && $past(guard_regs_lock_i, 8) |-> $stable(sector_guard_bits_o))
		else $error("guard moved locked");
	a_susp_holds: assert property (suspended_i && $past(suspended_i, 8) |-> $stable(sector_guard_bits_o))
		else $error("guard moved suspended");
	a_query_ok: assert property (!$past(sys_rst_i) |-> query_allowed_o == !sector_guard_bits_o[qs_d_r])
		else $error("query wrong");
endmodule
bind swg_guard swg_guard_monitor mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
	.guard_regs_lock_i(guard_regs_lock_i), .suspended_i(suspended_i), .query_sector_i(query_sector_i),
	.write_permit_latch_o(write_permit_latch_o), .sector_guard_bits_o(sector_guard_bits_o),
	.query_allowed_o(query_allowed_o));

// file: verification/swg_host.sv
`timescale 1ns/100ps
module swg_host (
	output logic sck_o,
	output logic cs_n_o,
	output logic sdi_o
);
	initial begin
		sck_o = 1'h0;
		cs_n_o = 1'h1;
		sdi_o = 1'h0;
	end
	// mode 0, msb first; a bit count off a byte edge is only sent when asked for
	task automatic frame(input logic [47:0] d, input int n);
		cs_n_o = 1'h0;
		for (int i = 0; i < n; i++) begin
			sdi_o = d[47-i];
			#32 sck_o = 1'h1;
			#32 sck_o = 1'h0;
		end
		#32 cs_n_o = 1'h1;
		sdi_o = ~sdi_o;
	endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
	logic clk_i = 1'h0, sys_rst_i = 1'h1, lock = 1'h0, susp = 1'h0, chk = 1'h0, latch, el, qa, sck, cs_n, sdi;
	logic [4:0] qs = 5'h00;
	logic [31:0] eg, guard;
	logic [33:0] e;
	logic [33:0] exq[$];
	logic [7:0] ops[6] = '{8'h06, 8'h36, 8'h06, 8'h39, 8'h04, 8'h06};
	int lens[8] = '{8, 32, 40, 32, 5, 24, 33, 16};
	int n_fail = 0, comparisons = 0, cyc = 0;
	initial forever #2.5 clk_i = ~clk_i;
	swg_host host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));
	swg_guard dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
		.guard_regs_lock_i(lock), .suspended_i(susp), .query_sector_i(qs),
		.write_permit_latch_o(latch), .sector_guard_bits_o(guard), .query_allowed_o(qa));
	task automatic final_report;
		if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic run(input logic [7:0] op, input int n, input logic lk, input logic sp);
		logic [23:0] a;
		a = 24'($urandom);
		lock = lk;
		susp = sp;
		qs = a[20:16];
		host.frame({op, a, 8'($urandom), 8'h00}, n);
		if (n % 8 == 0 && op == swg_pkg::OP_SET_LATCH) el = 1'h1;
		if (n % 8 == 0 && op == swg_pkg::OP_CLR_LATCH) el = 1'h0;
		// only the two guard opcodes have bit 4 set
		if (op[4] && n >= 8 && el && !sp) begin
			if (n % 8 == 0 && n >= 32 && !lk) eg[a[20:16]] = op == swg_pkg::OP_PROTECT;
			el = 1'h0;
		end
		repeat (8) @(negedge clk_i);
		exq.push_back({el, eg, ~eg[a[20:16]]});
		chk = 1'h1;
		@(negedge clk_i);
		chk = 1'h0;
	endtask
	always @(posedge clk_i) if (chk) begin
		e = exq.pop_front();
		`CHK("latch guard query", e, {latch, guard, qa})
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		el = swg_pkg::WRITE_PERMIT_RESET;
		eg = swg_pkg::GUARD_RESET;
		void'($urandom(32'h844f33da));
		repeat (10) @(negedge clk_i);
		sys_rst_i = 1'h0;
		repeat (6) @(negedge clk_i);
		run(8'h00, 8, 1'h0, 1'h0);
		for (int i = 0; i < 120; i++) run(ops[$urandom % 6], lens[$urandom % 8], $urandom % 5 == 0, $urandom % 6 == 0);
		sys_rst_i = 1'h1;
		repeat (3) @(negedge clk_i);
		sys_rst_i = 1'h0;
		el = swg_pkg::WRITE_PERMIT_RESET;
		eg = swg_pkg::GUARD_RESET;
		repeat (6) @(negedge clk_i);
		run(8'h00, 8, 1'h0, 1'h0);
		final_report();
	end
endmodule
